// *** logic/fuse_tap_port.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - first falling tms edge after power-up enters fuse check mode
// - tms already low when power-up finishes also enters fuse check mode
// - second rising tms edge after power-up leaves fuse check mode
// - once left, fuse check stays off until next power-on reset
// - fuse check mode enables continuity path from vpp pin to ground
// - blown security fuse permanently blocks all test port access
// - shared data-output pin is high impedance after power-on reset
// - during programming, test input data is taken from shared data pin
module fuse_tap_port (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        tck,
	input  wire logic        tms,
	input  wire logic        tdi_vpp,
	input  wire logic        tdo_tdi_in,
	input  wire logic        fuse_blown,
	input  wire logic        prog_mode,
	output logic             tdo_tdi_out,
	output logic             tdo_tdi_oe_n,
	output logic             fuse_check_en,
	output logic             port_locked,
	output logic [15:0]      data_word,
	output logic             data_valid
);

	// ==========================================================
	// tms, fuse and prog_mode seen from system clock
	logic tms_s;
	logic fuse_s;
	logic prog_s;

	// no reset: level already valid when reset is released
	sync2 u_sync_tms (
		.clk (clk_sys),
		.rst (1'b0),
		.d   (tms),
		.q   (tms_s)
	);

	sync2 u_sync_fuse (
		.clk (clk_sys),
		.rst (1'b0),
		.d   (fuse_blown),
		.q   (fuse_s)
	);

	sync2 u_sync_prog (
		.clk (clk_sys),
		.rst (rst),
		.d   (prog_mode),
		.q   (prog_s)
	);

	// ==========================================================
	// fuse check mode, system domain
	logic       first_q;
	logic       first_d;
	logic       tms_prev_q;
	logic       tms_prev_d;
	logic       armed_q;
	logic       armed_d;
	logic       check_q;
	logic       check_d;
	logic [1:0] rises_q;
	logic [1:0] rises_d;
	logic       lock_q;
	logic       lock_d;

	always_comb begin
		first_d    = 1'b0;
		tms_prev_d = tms_s;
		armed_d    = armed_q;
		check_d    = check_q;
		rises_d    = rises_q;
		lock_d     = lock_q | fuse_s;
		if (first_q) begin
			if (!tms_s) begin
				check_d = 1'b1;
			end
		end else if (armed_q) begin
			if (tms_prev_q && !tms_s) begin
				check_d = 1'b1;
			end
			if (!tms_prev_q && tms_s) begin
				rises_d = rises_q + 2'h1;
				if (rises_q + 2'h1 == fuse_tap_pkg::RISE_EXIT) begin
					check_d = 1'b0;
					armed_d = 1'b0;
				end
			end
		end
		if (lock_d) begin
			check_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			first_q    <= 1'b1;
			tms_prev_q <= 1'b1;
			armed_q    <= 1'b1;
			check_q    <= 1'b0;
			rises_q    <= 2'h0;
			lock_q     <= 1'b0;
		end else begin
			first_q    <= first_d;
			tms_prev_q <= tms_prev_d;
			armed_q    <= armed_d;
			check_q    <= check_d;
			rises_q    <= rises_d;
			lock_q     <= lock_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fuse_check_en <= 1'b0;
			port_locked   <= 1'b0;
		end else begin
			fuse_check_en <= check_d;
			port_locked   <= lock_d;
		end
	end

	// ==========================================================
	// control into tck domain
	logic lock_t;
	logic prog_t;
	logic rst_t;

	sync2 u_sync_lock (
		.clk (tck),
		.rst (1'b0),
		.d   (lock_q),
		.q   (lock_t)
	);

	sync2 u_sync_prog_t (
		.clk (tck),
		.rst (1'b0),
		.d   (prog_s),
		.q   (prog_t)
	);

	sync2 u_sync_rst (
		.clk (tck),
		.rst (1'b0),
		.d   (rst),
		.q   (rst_t)
	);

	// ==========================================================
	// tap machine, tck domain
	fuse_tap_pkg::tap_state_t st_q;
	fuse_tap_pkg::tap_state_t st_d;
	logic [3:0]               ir_sh_q;
	logic [3:0]               ir_sh_d;
	logic [3:0]               ir_q;
	logic [3:0]               ir_d;
	logic [31:0]              dr_sh_q;
	logic [31:0]              dr_sh_d;
	logic [15:0]              dr_q;
	logic [15:0]              dr_d;
	logic                     upd_tgl_q;
	logic                     upd_tgl_d;
	logic                     tdi_bit;

	always_comb begin
		tdi_bit = prog_t ? tdo_tdi_in : tdi_vpp;
		st_d    = st_q;
		case (st_q)
			fuse_tap_pkg::ST_RESET:    st_d = tms ? fuse_tap_pkg::ST_RESET : fuse_tap_pkg::ST_IDLE;
			fuse_tap_pkg::ST_IDLE:     st_d = tms ? fuse_tap_pkg::ST_SEL_DR : fuse_tap_pkg::ST_IDLE;
			fuse_tap_pkg::ST_SEL_DR:   st_d = tms ? fuse_tap_pkg::ST_SEL_IR : fuse_tap_pkg::ST_CAP_DR;
			fuse_tap_pkg::ST_CAP_DR:   st_d = tms ? fuse_tap_pkg::ST_EXIT1_DR : fuse_tap_pkg::ST_SHIFT_DR;
			fuse_tap_pkg::ST_SHIFT_DR: st_d = tms ? fuse_tap_pkg::ST_EXIT1_DR : fuse_tap_pkg::ST_SHIFT_DR;
			fuse_tap_pkg::ST_EXIT1_DR: st_d = tms ? fuse_tap_pkg::ST_UPD_DR : fuse_tap_pkg::ST_PAUSE_DR;
			fuse_tap_pkg::ST_PAUSE_DR: st_d = tms ? fuse_tap_pkg::ST_EXIT2_DR : fuse_tap_pkg::ST_PAUSE_DR;
			fuse_tap_pkg::ST_EXIT2_DR: st_d = tms ? fuse_tap_pkg::ST_UPD_DR : fuse_tap_pkg::ST_SHIFT_DR;
			fuse_tap_pkg::ST_UPD_DR:   st_d = tms ? fuse_tap_pkg::ST_SEL_DR : fuse_tap_pkg::ST_IDLE;
			fuse_tap_pkg::ST_SEL_IR:   st_d = tms ? fuse_tap_pkg::ST_RESET : fuse_tap_pkg::ST_CAP_IR;
			fuse_tap_pkg::ST_CAP_IR:   st_d = tms ? fuse_tap_pkg::ST_EXIT1_IR : fuse_tap_pkg::ST_SHIFT_IR;
			fuse_tap_pkg::ST_SHIFT_IR: st_d = tms ? fuse_tap_pkg::ST_EXIT1_IR : fuse_tap_pkg::ST_SHIFT_IR;
			fuse_tap_pkg::ST_EXIT1_IR: st_d = tms ? fuse_tap_pkg::ST_UPD_IR : fuse_tap_pkg::ST_PAUSE_IR;
			fuse_tap_pkg::ST_PAUSE_IR: st_d = tms ? fuse_tap_pkg::ST_EXIT2_IR : fuse_tap_pkg::ST_PAUSE_IR;
			fuse_tap_pkg::ST_EXIT2_IR: st_d = tms ? fuse_tap_pkg::ST_UPD_IR : fuse_tap_pkg::ST_SHIFT_IR;
			fuse_tap_pkg::ST_UPD_IR:   st_d = tms ? fuse_tap_pkg::ST_SEL_DR : fuse_tap_pkg::ST_IDLE;
			default:                   st_d = fuse_tap_pkg::ST_RESET;
		endcase
		ir_sh_d   = ir_sh_q;
		ir_d      = ir_q;
		dr_sh_d   = dr_sh_q;
		dr_d      = dr_q;
		upd_tgl_d = upd_tgl_q;
		case (st_q)
			fuse_tap_pkg::ST_RESET: begin
				ir_d = fuse_tap_pkg::IR_IDCODE;
			end
			fuse_tap_pkg::ST_CAP_IR: begin
				ir_sh_d = fuse_tap_pkg::IR_CAPTURE;
			end
			fuse_tap_pkg::ST_SHIFT_IR: begin
				ir_sh_d = {tdi_bit, ir_sh_q[3:1]};
			end
			fuse_tap_pkg::ST_UPD_IR: begin
				ir_d = ir_sh_q;
			end
			fuse_tap_pkg::ST_CAP_DR: begin
				if (ir_q == fuse_tap_pkg::IR_IDCODE) begin
					dr_sh_d = fuse_tap_pkg::ID_VALUE;
				end else if (ir_q == fuse_tap_pkg::IR_DATA) begin
					dr_sh_d = {16'h0000, dr_q};
				end else begin
					dr_sh_d = 32'h0000_0000;
				end
			end
			fuse_tap_pkg::ST_SHIFT_DR: begin
				if (ir_q == fuse_tap_pkg::IR_DATA) begin
					dr_sh_d = {16'h0000, tdi_bit, dr_sh_q[15:1]};
				end else if (ir_q == fuse_tap_pkg::IR_IDCODE) begin
					dr_sh_d = {tdi_bit, dr_sh_q[31:1]};
				end else begin
					dr_sh_d = {31'h0000_0000, tdi_bit};
				end
			end
			fuse_tap_pkg::ST_UPD_DR: begin
				if (ir_q == fuse_tap_pkg::IR_DATA) begin
					dr_d      = dr_sh_q[15:0];
					upd_tgl_d = ~upd_tgl_q;
				end
			end
			default: begin
				ir_d = ir_q;
			end
		endcase
	end

	always_ff @(posedge tck) begin
		if (rst_t || lock_t) begin
			st_q      <= fuse_tap_pkg::ST_RESET;
			ir_sh_q   <= fuse_tap_pkg::IR_CAPTURE;
			ir_q      <= fuse_tap_pkg::IR_IDCODE;
			dr_sh_q   <= 32'h0000_0000;
			dr_q      <= fuse_tap_pkg::DATA_RESET;
			upd_tgl_q <= 1'b0;
		end else begin
			st_q      <= st_d;
			ir_sh_q   <= ir_sh_d;
			ir_q      <= ir_d;
			dr_sh_q   <= dr_sh_d;
			dr_q      <= dr_d;
			upd_tgl_q <= upd_tgl_d;
		end
	end

	// ==========================================================
	// tdo on falling tck, released unless shifting with prog_mode off
	logic shifting;
	logic tdo_bit;

	always_comb begin
		shifting = (st_q == fuse_tap_pkg::ST_SHIFT_DR) || (st_q == fuse_tap_pkg::ST_SHIFT_IR);
		tdo_bit  = (st_q == fuse_tap_pkg::ST_SHIFT_IR) ? ir_sh_q[0] : dr_sh_q[0];
	end

	always_ff @(negedge tck) begin
		if (rst_t || lock_t) begin
			tdo_tdi_out  <= 1'b0;
			tdo_tdi_oe_n <= 1'b1;
		end else begin
			tdo_tdi_out  <= tdo_bit;
			tdo_tdi_oe_n <= ~shifting | prog_t;
		end
	end

	// ==========================================================
	// data update back to system clock, toggle crossing
	logic upd_s;
	logic upd_prev_q;
	logic upd_prev_d;
	logic [15:0] data_d;
	logic valid_d;

	sync2 u_sync_upd (
		.clk (clk_sys),
		.rst (rst),
		.d   (upd_tgl_q),
		.q   (upd_s)
	);

	always_comb begin
		upd_prev_d = upd_s;
		valid_d    = (upd_s != upd_prev_q) && !lock_q;
		data_d     = valid_d ? dr_q : data_word;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			upd_prev_q <= 1'b0;
			data_word  <= fuse_tap_pkg::DATA_RESET;
			data_valid <= 1'b0;
		end else begin
			upd_prev_q <= upd_prev_d;
			data_word  <= data_d;
			data_valid <= valid_d;
		end
	end

endmodule

// *** common/fuse_tap_pkg.sv ***
package fuse_tap_pkg;

	// ==========================================================
	// tap states, gray along the reset/idle/dr path
	typedef enum logic [3:0] {
		ST_RESET     = 4'h0,
		ST_IDLE      = 4'h1,
		ST_SEL_DR    = 4'h3,
		ST_CAP_DR    = 4'h2,
		ST_SHIFT_DR  = 4'h6,
		ST_EXIT1_DR  = 4'h7,
		ST_PAUSE_DR  = 4'h5,
		ST_EXIT2_DR  = 4'h4,
		ST_UPD_DR    = 4'hc,
		ST_SEL_IR    = 4'hd,
		ST_CAP_IR    = 4'hf,
		ST_SHIFT_IR  = 4'he,
		ST_EXIT1_IR  = 4'ha,
		ST_PAUSE_IR  = 4'hb,
		ST_EXIT2_IR  = 4'h9,
		ST_UPD_IR    = 4'h8
	} tap_state_t;

	// ==========================================================
	// instruction register
	localparam int          IR_W        = 4;
	localparam logic [3:0]  IR_CAPTURE  = 4'h1;
	localparam logic [3:0]  IR_RESET    = 4'hf;
	localparam logic [3:0]  IR_BYPASS   = 4'hf;
	localparam logic [3:0]  IR_IDCODE   = 4'h2;
	localparam logic [3:0]  IR_DATA     = 4'h4;

	// ==========================================================
	// data registers
	localparam int          DR_W        = 16;
	localparam logic [31:0] ID_VALUE    = 32'h0000_1001; // arbitrary value
	localparam logic [15:0] DATA_RESET  = 16'h0000;

	// ==========================================================
	// tms edge counting for fuse check
	localparam logic [1:0]  RISE_EXIT   = 2'h2;

endpackage

// *** logic/sync2.sv ***
`timescale 1ns/100ps
module sync2 (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic d,
	output logic      q
);

	logic meta_q;
	logic meta_d;
	logic q_d;

	// ==========================================================
	// two flop level synchroniser
	always_comb begin
		meta_d = d;
		q_d    = meta_q;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= 1'b0;
			q      <= 1'b0;
		end else begin
			meta_q <= meta_d;
			q      <= q_d;
		end
	end

endmodule

// *** test/fuse_tap_chk.sv ***
`timescale 1ns/100ps
module fuse_tap_chk (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic tms,
	input wire logic fuse_blown,
	input wire logic tdo_tdi_oe_n,
	input wire logic fuse_check_en,
	input wire logic port_locked,
	input wire logic data_valid
);
	// ==========
	// tms rises since reset, cycles since second rise
	logic       tms_q;
	logic       tms_d;
	logic [1:0] rise_q;
	logic [1:0] rise_d;
	logic [2:0] off_q;
	logic [2:0] off_d;
	always_comb begin
		tms_d = tms;
		rise_d = rst ? 2'h0 : rise_q + {1'b0, tms & !tms_q & (rise_q != 2'h2)};
		off_d = rst ? 3'h0 : off_q + {2'h0, (rise_q == 2'h2) & (off_q != 3'h7)};
	end
	always_ff @(posedge clk_sys) begin
		tms_q <= tms_d;
		rise_q <= rise_d;
		off_q <= off_d;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ==========
	// assertions
	oe_por_a: assert property ($fell(rst) |-> tdo_tdi_oe_n)
		else $error("shared pin driven after reset");
	por_low_a: assert property ($fell(rst) && !tms && !fuse_blown |-> ##[1:5] fuse_check_en)
		else $error("no fuse check with tms low");
	first_fall_a: assert property ($fell(tms) && rise_q == 2'h0 && !fuse_blown |-> ##[1:6] fuse_check_en)
		else $error("no fuse check on first fall");
	exit_a: assert property ($rose(tms) && rise_q == 2'h1 |-> ##[1:6] !fuse_check_en)
		else $error("fuse check kept after second rise");
	stay_off_a: assert property (off_q == 3'h7 |-> !fuse_check_en)
		else $error("fuse check back before reset");
	lock_set_a: assert property (fuse_blown [*5] |-> port_locked)
		else $error("blown fuse not locked");
	lock_sticky_a: assert property (port_locked |=> port_locked)
		else $error("lock released");
	lock_off_a: assert property (port_locked |=> !fuse_check_en)
		else $error("fuse check while locked");
	lock_quiet_a: assert property (port_locked ##1 port_locked |-> tdo_tdi_oe_n && !data_valid)
		else $error("port active while locked");
	pulse_a: assert property (data_valid |=> !data_valid)
		else $error("data valid too long");
	cover property (fuse_check_en ##1 !fuse_check_en);
	cover property ($rose(port_locked));
	cover property (data_valid);
endmodule
bind fuse_tap_port fuse_tap_chk chk (
	.clk_sys(clk_sys),
	.rst(rst),
	.tms(tms),
	.fuse_blown(fuse_blown),
	.tdo_tdi_oe_n(tdo_tdi_oe_n),
	.fuse_check_en(fuse_check_en),
	.port_locked(port_locked),
	.data_valid(data_valid)
);

// *** test/jtag_host.sv ***
`timescale 1ns/100ps
module jtag_host (
	input  wire logic pin,
	input  wire logic prog,
	output logic      tck,
	output logic      tms,
	output logic      tdi_vpp,
	output logic      prog_dat
);
	int half = 16;
	localparam int FAST_PULSE_NS = 100000;
	localparam int FAST_PULSES   = 4;
	localparam int BLOW_NS       = 500000; // kept under the 1 ms blow limit
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi_vpp = 1'b0;
		prog_dat = 1'b0;
	end
	// ==========
	// one tck period, tck idle outside frames
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi_vpp = prog ? 1'b1 : d;
		prog_dat = d;
		#(half);
		o = pin;
		tck = 1'b1;
		#(half);
		tck = 1'b0;
	endtask
	// ir or dr scan from idle back to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] d, output logic [31:0] q);
		logic b;
		q = 32'h0;
		step(1'b0, 1'b0, b);
		step(1'b1, 1'b0, b);
		if (ir) begin
			step(1'b1, 1'b0, b);
		end
		step(1'b0, 1'b0, b);
		step(1'b0, 1'b0, b);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, d[i], b);
			q[i] = b;
		end
		step(1'b1, 1'b0, b);
		step(1'b0, 1'b0, b);
	endtask
	// high voltage pulses on the vpp pin, tck idle
	task automatic vpp_pulses(input int n, input int w);
		for (int i = 0; i < n; i++) begin
			tdi_vpp = 1'b1;
			#(w);
			tdi_vpp = 1'b0;
			#(w);
		end
	endtask
endmodule

// *** test/testbench.sv ***
`timescale 1ns/100ps
module testbench;
	logic        clk_sys;
	logic        rst;
	logic        fuse_blown;
	logic        prog_mode;
	logic        tck;
	logic        tms;
	logic        tdi_vpp;
	logic        pin;
	logic        pdat;
	logic        tdo_o;
	logic        oe_n;
	logic        fc_en;
	logic        locked;
	logic        dv;
	logic [15:0] dword;
	logic [31:0] q;
	int          error_cnt = 0;
	int          checks = 0;
	int          dv_cnt = 0;
	int          clash_cnt = 0;
	int          n;
	// shared pin: device, else programmer, else pulldown
	assign pin = !oe_n ? tdo_o : (prog_mode ? pdat : 1'b0);
	fuse_tap_port uut (.clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms), .tdi_vpp(tdi_vpp), .tdo_tdi_in(pin),
		.fuse_blown(fuse_blown), .prog_mode(prog_mode), .tdo_tdi_out(tdo_o), .tdo_tdi_oe_n(oe_n),
		.fuse_check_en(fc_en), .port_locked(locked), .data_word(dword), .data_valid(dv));
	jtag_host host (.pin(pin), .prog(prog_mode), .tck(tck), .tms(tms), .tdi_vpp(tdi_vpp), .prog_dat(pdat));
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (dv === 1'b1) dv_cnt++;
	end
	// device must not drive the shared pin while the programmer uses it
	always @(posedge tck) begin
		if (prog_mode === 1'b1 && oe_n !== 1'b1) clash_cnt++;
	end
	// ==========
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk_sys);
	endtask
	task automatic tms_to(input logic v);
		cyc(1);
		host.tms = v;
		cyc(6);
	endtask
	task automatic por(input logic m);
		logic b;
		@(negedge clk_sys);
		rst = 1'b1;
		repeat (5) host.step(1'b1, 1'b0, b);
		host.tms = m;
		cyc(20);
		rst = 1'b0;
		repeat (3) host.step(m, 1'b0, b);
		cyc(6);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ==========
	// scenarios
	task automatic t_edges;
		por(1'b1);
		chk(oe_n, 1);
		chk(fc_en, 0);
		tms_to(1'b0);
		chk(fc_en, 1);
		tms_to(1'b1);
		chk(fc_en, 1);
		tms_to(1'b0);
		tms_to(1'b1);
		chk(fc_en, 0);
		tms_to(1'b0);
		chk(fc_en, 0);
		por(1'b1);
		tms_to(1'b0);
		chk(fc_en, 1);
		por(1'b0);
		chk(fc_en, 1);
		$display("edges done");
	endtask
	task automatic t_tap;
		por(1'b1);
		host.scan(1'b1, 4, {28'h0, fuse_tap_pkg::IR_IDCODE}, q);
		host.scan(1'b0, 32, 32'h0, q);
		chk(q, fuse_tap_pkg::ID_VALUE);
		host.scan(1'b1, 4, {28'h0, fuse_tap_pkg::IR_DATA}, q);
		n = dv_cnt;
		host.scan(1'b0, 16, 32'ha5c3, q);
		cyc(6);
		chk(dword, 16'ha5c3);
		chk(dv_cnt - n, 1);
		$display("tap done");
	endtask
	task automatic t_prog;
		prog_mode = 1'b1;
		cyc(3);
		host.scan(1'b1, 4, {28'h0, fuse_tap_pkg::IR_DATA}, q);
		host.scan(1'b0, 16, 32'h3c96, q);
		host.vpp_pulses(host.FAST_PULSES, host.FAST_PULSE_NS);
		cyc(6);
		chk(dword, 16'h3c96);
		chk(oe_n, 1);
		chk(clash_cnt, 0);
		prog_mode = 1'b0;
		$display("prog done");
	endtask
	task automatic t_lock;
		prog_mode = 1'b1;
		host.vpp_pulses(1, host.BLOW_NS);
		fuse_blown = 1'b1;
		prog_mode = 1'b0;
		cyc(6);
		chk(locked, 1);
		chk(fc_en, 0);
		n = dv_cnt;
		host.scan(1'b1, 4, {28'h0, fuse_tap_pkg::IR_DATA}, q);
		host.scan(1'b0, 16, 32'h1234, q);
		cyc(6);
		chk(dv_cnt - n, 0);
		chk(dword, 16'h3c96);
		por(1'b0);
		chk(locked, 1);
		chk(fc_en, 0);
		$display("lock done");
	endtask
	initial begin
		rst = 1'b1;
		fuse_blown = 1'b0;
		prog_mode = 1'b0;
		t_edges();
		t_tap();
		t_prog();
		t_lock();
		tally_and_finish();
	end
	initial begin
		#4000000;
		error_cnt++;
		tally_and_finish();
	end
endmodule
